// ===== common/dsc_cfg_map.svh
// Purpose: Slave address, field positions, reset values and counts for dsc block
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef DSC_CFG_MAP_SVH
`define DSC_CFG_MAP_SVH

`define DSC_CFG_RESET      8'h00
`define DSC_GAIN_LSB       5
`define DSC_TEMP_BIT       3
`define DSC_REJ_LSB        1
`define DSC_RATE_BIT       0
`define DSC_BITS_PER_BYTE  4'h8
`define DSC_ACK_SLOT       4'h8
`define DSC_READ_BYTES     2'h3
`define DSC_SLAVE_ADDR     7'h14
`define DSC_CONV_CYCLES    16'h0100

`endif

// ===== common/dsc_pkg.sv
// Purpose: Types for dsc slave front end
// Assumes: Nothing
// Notes:   Holds types only
`default_nettype none
package dsc_pkg;

   typedef struct packed {
      logic [2:0] gain_sel;
      logic       reserved_bit;
      logic       temp_sensor_select;
      logic       rejection_sel_a;
      logic       rejection_sel_b;
      logic       double_rate_select;
   } dsc_cfg_type;

   typedef struct packed {
      logic        temp_input;
      logic [8:0]  gain;
      logic [1:0]  rejection;
      logic        offset_cal_on;
   } dsc_mode_type;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_ADDR = 6'b00_0010,
      ST_WDAT = 6'b00_0100,
      ST_RDAT = 6'b00_1000,
      ST_ACK  = 6'b01_0000,
      ST_WAIT = 6'b10_0000
   } dsc_state_type;

endpackage
`default_nettype wire

// ===== hw/dsc_i2c_slave.sv
// Purpose: I2C slave serial front end with configuration word capture
// Assumes: sys_clk_i far faster than scl; pins already pulled up outside
// Notes:   Conversion itself is modelled by a timer and a result input
`default_nettype none
`include "dsc_cfg_map.svh"

module dsc_i2c_slave
   import dsc_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = 256
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rst_n_i,
   // I2C pins
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   output logic              sda_o,
   output logic              sda_oe_n_o,
   // Conversion result
   input  wire logic [17:0]  result_i,
   // Mode and status
   output dsc_mode_type      mode_o,
   output logic              converting_o,
   output logic              conv_start_o
);

   // ********************************************************
   // Input synchronisers and edge detection
   // ********************************************************
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_prev_reg;
   logic       sda_prev_reg;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_s     = scl_sync_reg[1];
   assign sda_s     = sda_sync_reg[1];
   assign scl_rise  = scl_s && !scl_prev_reg;
   assign scl_fall  = !scl_s && scl_prev_reg;
   assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
   assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

   // ********************************************************
   // Mode decode
   // ********************************************************
   function automatic dsc_mode_type decode_mode(input dsc_cfg_type c);
      dsc_mode_type m;
      m.temp_input    = c.temp_sensor_select;
      m.rejection     = {c.rejection_sel_a, c.rejection_sel_b};
      if (c.temp_sensor_select) begin
         m.gain          = 9'h001;
         m.offset_cal_on = 1'b1;
      end else if (c.double_rate_select) begin
         m.gain          = 9'h001 << c.gain_sel;
         m.offset_cal_on = 1'b0;
      end else begin
         m.gain          = (c.gain_sel == 3'h0) ? 9'h001 :
                           9'(9'h002 << c.gain_sel);
         m.offset_cal_on = 1'b1;
      end
      return m;
   endfunction

   // ********************************************************
   // Serial state machine
   // ********************************************************
   dsc_state_type state_reg;
   logic [3:0]    bit_cnt_reg;
   logic [7:0]    shift_reg;
   logic          is_read_reg;
   logic          ack_me_reg;
   logic [1:0]    rd_byte_reg;
   logic          wrote_reg;
   logic [23:0]   out_word_reg;
   dsc_cfg_type   cfg_reg;
   dsc_cfg_type   pend_cfg_reg;
   logic          read_done;

   assign read_done = (state_reg == ST_ACK) && is_read_reg && scl_fall &&
                      (rd_byte_reg == `DSC_READ_BYTES);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         is_read_reg <= 1'b0;
         ack_me_reg  <= 1'b0;
         rd_byte_reg <= 2'h0;
         wrote_reg   <= 1'b0;
      end else if (start_det) begin
         state_reg   <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         rd_byte_reg <= 2'h0;
      end else if (stop_det) begin
         state_reg   <= ST_IDLE;
         wrote_reg   <= 1'b0;
      end else if (read_done) begin
         state_reg   <= ST_WAIT;
      end else begin
         case (state_reg)
            ST_ADDR, ST_WDAT, ST_RDAT: begin
               if (scl_rise && state_reg != ST_RDAT) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
               end
               if (scl_rise) begin
                  bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
               end
               if (scl_fall && bit_cnt_reg == `DSC_BITS_PER_BYTE) begin
                  state_reg <= ST_ACK;
                  if (state_reg == ST_ADDR) begin
                     is_read_reg <= shift_reg[0];
                     ack_me_reg  <= (shift_reg[7:1] == `DSC_SLAVE_ADDR) &&
                                    !converting_o &&
                                    !(shift_reg[0] && rd_byte_reg != 2'h0);
                  end else if (state_reg == ST_WDAT) begin
                     wrote_reg   <= 1'b1;
                     ack_me_reg  <= 1'b1;
                  end else begin
                     rd_byte_reg <= 2'(rd_byte_reg + 2'h1);
                     ack_me_reg  <= 1'b0;
                  end
               end
            end
            ST_ACK: begin
               if (scl_rise) begin
                  bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                  if (is_read_reg && rd_byte_reg != 2'h0) begin
                     ack_me_reg <= !sda_s;
                  end
               end
               if (scl_fall && bit_cnt_reg == 4'h9) begin
                  bit_cnt_reg <= 4'h0;
                  if (!is_read_reg && ack_me_reg && !wrote_reg) begin
                     state_reg <= ST_WDAT;
                  end else if (is_read_reg && ack_me_reg) begin
                     state_reg  <= ST_RDAT;
                     ack_me_reg <= 1'b0;
                  end else begin
                     state_reg <= ST_WAIT;
                  end
               end
            end
            ST_IDLE, ST_WAIT: begin
               bit_cnt_reg <= 4'h0;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ********************************************************
   // Configuration capture
   // ********************************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pend_cfg_reg <= `DSC_CFG_RESET;
      end else if (state_reg == ST_WDAT && scl_fall &&
                   bit_cnt_reg == `DSC_BITS_PER_BYTE) begin
         pend_cfg_reg <= shift_reg;
      end
   end

   // ********************************************************
   // Conversion timer
   // ********************************************************
   logic [15:0] conv_cnt_reg;
   logic        conv_go;

   assign conv_go = (stop_det && wrote_reg) || read_done;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         converting_o <= 1'b1;
         conv_start_o <= 1'b0;
         conv_cnt_reg <= 16'(CONV_CYCLES);
         cfg_reg      <= `DSC_CFG_RESET;
         out_word_reg <= 24'h00_0000;
         mode_o       <= decode_mode(`DSC_CFG_RESET);
      end else begin
         conv_start_o <= conv_go;
         if (conv_go) begin
            converting_o <= 1'b1;
            conv_cnt_reg <= 16'(CONV_CYCLES);
            if (stop_det && wrote_reg) begin
               cfg_reg <= pend_cfg_reg;
               mode_o  <= decode_mode(pend_cfg_reg);
            end
         end else if (converting_o) begin
            if (conv_cnt_reg == 16'h0000) begin
               converting_o <= 1'b0;
               out_word_reg <= {result_i, cfg_reg[7:5],
                                cfg_reg[3:1]};
            end else begin
               conv_cnt_reg <= 16'(conv_cnt_reg - 16'h0001);
            end
         end
      end
   end

   // ********************************************************
   // Open-drain data driver
   // ********************************************************
   logic [4:0] rd_index;

   assign rd_index = 5'(5'd23 - 5'(rd_byte_reg) * 5'd8 -
                        5'(bit_cnt_reg));

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sda_oe_n_o <= 1'b1;
         sda_o      <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe_n_o <= 1'b1;
      end else if (scl_fall) begin
         sda_o <= 1'b0;
         if (state_reg != ST_ACK && bit_cnt_reg == `DSC_BITS_PER_BYTE &&
             state_reg != ST_RDAT &&
             (state_reg == ST_WDAT ||
              ((shift_reg[7:1] == `DSC_SLAVE_ADDR) && !converting_o &&
               !(shift_reg[0] && rd_byte_reg != 2'h0)))) begin
            sda_oe_n_o <= 1'b0;
         end else if (state_reg == ST_ACK && bit_cnt_reg == 4'h9 &&
                      is_read_reg && ack_me_reg &&
                      rd_byte_reg != `DSC_READ_BYTES) begin
            sda_oe_n_o <= out_word_reg[5'(5'd23 - 5'(rd_byte_reg) * 5'd8)];
         end else if (state_reg == ST_RDAT &&
                      bit_cnt_reg < `DSC_BITS_PER_BYTE) begin
            sda_oe_n_o <= out_word_reg[rd_index];
         end else begin
            sda_oe_n_o <= 1'b1;
         end
      end
   end

   // ********************************************************
   // Checks
   // ********************************************************
   property p_never_high;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !sda_o;
   endproperty
   a_never_high: assert property (p_never_high)
      else $error("data driven high");

   property p_idle_release;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      stop_det |=> sda_oe_n_o;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("data held after stop");

   property p_start_addr;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      start_det |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0;
   endproperty
   a_start_addr: assert property (p_start_addr)
      else $error("start not taken");

   property p_stop_idle;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      stop_det && !start_det |=> state_reg == ST_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop not taken");

   property p_change_low;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      $changed(sda_oe_n_o) && !$past(start_det) && !$past(stop_det)
         |-> !scl_prev_reg;
   endproperty
   a_change_low: assert property (p_change_low)
      else $error("data changed with clock high");

   property p_cfg_hold;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !$past(conv_go) |-> $stable(cfg_reg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("configuration changed without write");

   property p_busy_nack;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      state_reg == ST_ADDR && converting_o ##1 state_reg == ST_ACK
         |-> !ack_me_reg;
   endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("ack while converting");

   property p_conv_go;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      conv_go |=> converting_o && conv_start_o;
   endproperty
   a_conv_go: assert property (p_conv_go)
      else $error("conversion not started");

   property p_temp_gain;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      mode_o.temp_input |-> mode_o.gain == 9'h001 && mode_o.offset_cal_on;
   endproperty
   a_temp_gain: assert property (p_temp_gain)
      else $error("temperature mode gain wrong");

endmodule
`default_nettype wire

// ===== dv/dsc_i2c_master_model.sv
// Purpose: Behavioural I2C bus master for the slave front end
// Assumes: Pull-up on both lines; scl period 320 ns
// Notes:   Tasks are called by the bench; changes on falling clock
`default_nettype none
module dsc_i2c_master_model (
   // Clock
   input  wire logic sys_clk_i,
   // Bus lines
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Bus phases
   // ****
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic q();
      repeat (4) @(negedge sys_clk_i);
   endtask
   task automatic start();
      sda_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_o = 1'b0;
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_o = 1'b1;
      q();
   endtask
   task automatic clk_bit(input logic b, output logic s);
      sda_o = b;
      q();
      scl_o = 1'b1;
      q();
      s = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, ack);
   endtask
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(last, s);
   endtask
endmodule
`default_nettype wire

// ===== dv/dsc_i2c_slave_test.sv
// Purpose: Self-checking bench for the slave front end
// Assumes: Master model drives the bus
// Notes:   Mode is checked one cycle after each conversion start
`default_nettype none
`include "dsc_cfg_map.svh"
module dsc_i2c_slave_test;
   import dsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned CONV = 200;
   logic         sys_clk_i;
   logic         rst_n_i;
   logic         scl;
   logic         sda_m;
   logic [17:0]  result_i;
   logic [17:0]  res_now;
   logic [7:0]   cfg_now;
   logic         sda_o;
   logic         sda_oe_n;
   logic         converting;
   logic         conv_start;
   dsc_mode_type mode;
   dsc_mode_type mode_q[$];
   wire          sda_line;
   int           n_fail;
   int           check_count;
   assign sda_line = sda_m & (sda_oe_n | sda_o);
   dsc_i2c_slave #(.CONV_CYCLES(CONV)) uut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .result_i(result_i), .mode_o(mode), .converting_o(converting),
      .conv_start_o(conv_start));
   dsc_i2c_master_model master (
      .sys_clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_m));
   always #20 sys_clk_i = ~sys_clk_i;
   // ****
   // Helpers
   // ****
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   function automatic dsc_mode_type exp_mode(input logic [7:0] c);
      dsc_mode_type m;
      m.temp_input = c[3];
      m.rejection = c[2:1];
      m.offset_cal_on = c[3] | ~c[0];
      if (c[3] || c[7:5] == 3'h0) begin
         m.gain = 9'h001;
      end else if (c[0]) begin
         m.gain = 9'h001 << c[7:5];
      end else begin
         m.gain = 9'h002 << c[7:5];
      end
      return m;
   endfunction
   task automatic wait_ready();
      int n;
      n = 0;
      while (converting !== 1'b0) begin
         @(negedge sys_clk_i);
         n++;
         if (n > 1000) begin
            check("ready wait", 32'h0, 32'h1);
            wrap_up();
         end
      end
   endtask
   task automatic addr_only(input logic [7:0] a_byte, input logic exp);
      logic a;
      master.start();
      master.wr_byte(a_byte, a);
      check("addr ack", a, exp);
      master.stop();
   endtask
   task automatic cfg_write(input logic [7:0] c, input logic rs);
      logic a;
      master.start();
      if (rs) begin
         master.wr_byte({`DSC_SLAVE_ADDR, 1'b0}, a);
         check("rs ack", a, 1'b0);
         master.start();
      end
      master.wr_byte({`DSC_SLAVE_ADDR, 1'b0}, a);
      check("wr addr ack", a, 1'b0);
      master.wr_byte(c, a);
      check("data ack", a, 1'b0);
      master.wr_byte(8'h5A, a);
      check("extra ack", a, 1'b1);
      check("mode pre stop", mode, exp_mode(cfg_now));
      mode_q.push_back(exp_mode(c));
      master.stop();
      cfg_now = c;
   endtask
   task automatic res_read();
      logic        a;
      logic [7:0]  d;
      logic [23:0] exp;
      exp = {res_now, cfg_now[7:5], cfg_now[3:1]};
      master.start();
      master.wr_byte({`DSC_SLAVE_ADDR, 1'b1}, a);
      check("rd addr ack", a, 1'b0);
      for (int i = 2; i >= 0; i--) begin
         if (i == 0) begin
            mode_q.push_back(exp_mode(cfg_now));
         end
         master.rd_byte(i == 0, d);
         check("read byte", d, exp[i*8 +: 8]);
      end
      addr_only({`DSC_SLAVE_ADDR, 1'b1}, 1'b1);
   endtask
   // ****
   // Conversion start watcher
   // ****
   always @(negedge sys_clk_i) begin
      if (conv_start === 1'b1) begin
         @(negedge sys_clk_i);
         check("converting", converting, 1'b1);
         if (mode_q.size() == 0) begin
            check("spare start", 32'h1, 32'h0);
         end else begin
            check("mode", mode, mode_q.pop_front());
         end
         result_i = 18'($urandom);
         res_now = result_i;
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      logic [7:0] c;
      void'($urandom(32'h3151));
      sys_clk_i = 1'b0;
      rst_n_i = 1'b0;
      n_fail = 0;
      check_count = 0;
      cfg_now = 8'h00;
      result_i = 18'($urandom);
      res_now = result_i;
      repeat (20) @(negedge sys_clk_i);
      check("reset mode", mode, exp_mode(8'h00));
      check("reset sda", sda_oe_n, 1'b1);
      rst_n_i = 1'b1;
      $display("test reset done");
      addr_only({`DSC_SLAVE_ADDR, 1'b0}, 1'b1);
      wait_ready();
      addr_only({7'h15, 1'b0}, 1'b1);
      res_read();
      $display("test default read done");
      for (int k = 0; k < 23; k++) begin
         c = {k[2:0], 1'b0, k >= 16, 2'(k % 3), k[3]};
         if (k >= 19) begin
            c = 8'($urandom) & 8'hEF;
         end
         if (c[2:1] == 2'b11) begin
            c[2:1] = 2'b10;
         end
         wait_ready();
         cfg_write(c, k == 5);
         wait_ready();
         res_read();
         $display("test cfg %h done", c);
      end
      wait_ready();
      repeat (4) @(negedge sys_clk_i);
      check("pending starts", mode_q.size(), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
